// File: hw/sdcl_pkg.sv
package sdcl_pkg;
  // command code on {ras_n, cas_n, we_n} while cs_n is low
  localparam logic [2:0] CMD_READ = 3'b101;
  localparam logic [2:0] CMD_WRITE = 3'b100;
  localparam logic [2:0] CMD_REFRESH = 3'b001;
  // column field that selects the burst pattern
  localparam int COL_LO = 3;
  localparam int COL_HI = 6;
  localparam logic [3:0] COL_ONES = 4'hf;
  localparam logic [3:0] COL_ZERO = 4'h0;
  // burst data patterns, beat 0 in the msb
  localparam logic [7:0] PAT_ZERO = 8'h00;
  localparam logic [7:0] PAT_ALT = 8'h33;
  localparam int BURST_BEATS = 8;
  localparam int BEATS_PER_CLK = 2;
  localparam logic [1:0] BURST_LAST = 2'(BURST_BEATS / BEATS_PER_CLK - 1);
  localparam int BUF_DEPTH = 2;
  // synchronised command bundle layout
  localparam int SY_CS = 0;
  localparam int SY_RAS = 1;
  localparam int SY_CAS = 2;
  localparam int SY_WE = 3;
  localparam int SY_COL = 4;
  localparam int SY_WM = 8;
  localparam int SY_CKE = 9;
  localparam int SY_ODT = 10;
  localparam int SY_BA = 11;
  localparam int SY_W = 14;
  // idle pin levels: command pins high, clock enable high, mask and termination low
  localparam logic [SY_W-1:0] SY_IDLE = 14'h020f;
endpackage : sdcl_pkg

// File: hw/sdcl_read_path.sv
`timescale 1ns/1ps
// Contract
// - strobe pair toggles only for read bursts, otherwise mid-level
// - memory drives the commanded burst pattern on every data line per read
// - outside bursts the data lines are left undriven at mid-level
// - strobe and data lines stay mid-level through the refresh loop
module sdcl_read_path import sdcl_pkg::*; #(
  parameter int DQ_W = 8
) (
  input wire logic core_clk, // 25 MHz core clock
  input wire logic rst, // async reset, active high
  input wire logic cs_n, // chip select pin
  input wire logic ras_n, // row strobe pin
  input wire logic cas_n, // column strobe pin
  input wire logic we_n, // write enable pin
  input wire logic [2:0] ba, // bank select pins
  input wire logic [13:0] addr, // address pins
  input wire logic termination_enable, // termination pin
  input wire logic write_mask, // write mask pin
  input wire logic cke, // clock enable pin
  output logic [DQ_W-1:0] dq_rise_o, // data beat in first half clock
  output logic [DQ_W-1:0] dq_fall_o, // data beat in second half clock
  output logic dq_oe, // data lines driven
  output logic dqs_t_o, // strobe true level
  output logic dqs_c_o, // strobe complement level
  output logic dqs_oe, // strobe pair driven
  output logic [2:0] read_bank_o, // bank of the burst on the bus
  output logic protocol_fault, // sticky: pattern misuse seen
  output logic read_overrun // sticky: read dropped, buffer full
);

  // ==========================================================
  // pin synchronisers
  logic [SY_W-1:0] sy1_q;
  logic [SY_W-1:0] sy2_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // idle levels, so the release of reset shows no false fault
      sy1_q <= SY_IDLE;
      sy2_q <= SY_IDLE;
    end else begin
      sy1_q <= {ba, termination_enable, cke, write_mask, addr[COL_HI:COL_LO], we_n, cas_n, ras_n, cs_n};
      sy2_q <= sy1_q;
    end
  end

  logic [2:0] cmd;
  logic is_read;
  logic is_write;
  logic is_refresh;
  assign cmd = {sy2_q[SY_RAS], sy2_q[SY_CAS], sy2_q[SY_WE]};
  assign is_read = !sy2_q[SY_CS] && cmd == CMD_READ;
  assign is_write = !sy2_q[SY_CS] && cmd == CMD_WRITE;
  assign is_refresh = !sy2_q[SY_CS] && cmd == CMD_REFRESH;

  function automatic logic [7:0] pattern_for(input logic [3:0] col);
    pattern_for = (col == COL_ONES) ? PAT_ALT : PAT_ZERO;
  endfunction : pattern_for

  function automatic logic beat_bit(input logic [7:0] pat, input logic [1:0] clk_idx, input logic fall);
    logic [2:0] pos;
    pos = 3'(7 - 2 * clk_idx - fall);
    beat_bit = pat[pos];
  endfunction : beat_bit

  // ==========================================================
  // loop mode tracking and misuse detection
  logic in_write_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_write_q <= 1'b0;
    end else if (is_write) begin
      in_write_q <= 1'b1;
    end else if (is_read || is_refresh) begin
      in_write_q <= 1'b0;
    end
  end

  logic fault_now;
  // termination may rise before the first write, so until then only a write or a read/refresh judges it; after a write every cycle does until a read/refresh
  assign fault_now = sy2_q[SY_WM]
    || !sy2_q[SY_CKE]
    || ((in_write_q || is_write) ? !sy2_q[SY_ODT] : ((is_read || is_refresh) && sy2_q[SY_ODT]));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      protocol_fault <= 1'b0;
    end else if (fault_now) begin
      protocol_fault <= 1'b1;
    end
  end

  // ==========================================================
  // two-entry burst buffer
  // reads arrive every four clocks at most, the shifter drains one per four,
  // so a full buffer only means a misbehaving host
  logic [10:0] buf_q [BUF_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic in_valid;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  logic push;
  logic pop;

  assign in_valid = is_read;
  assign in_ready = count_q != 2'(BUF_DEPTH);
  assign out_valid = count_q != 2'd0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      count_q <= 2'(count_q + push - pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_q[wr_ptr_q] <= {sy2_q[SY_BA+2:SY_BA], pattern_for(sy2_q[SY_COL+3:SY_COL])};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      read_overrun <= 1'b0;
    end else if (in_valid && !in_ready) begin
      read_overrun <= 1'b1;
    end
  end

  // ==========================================================
  // burst shifter onto the data and strobe pins
  logic active_q;
  logic [1:0] beat_q;
  logic [7:0] pat_q;

  assign out_ready = !active_q || beat_q == BURST_LAST;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
      beat_q <= 2'd0;
      pat_q <= PAT_ZERO;
      read_bank_o <= 3'd0;
    end else if (pop) begin
      active_q <= 1'b1;
      beat_q <= 2'd0;
      pat_q <= buf_q[rd_ptr_q][7:0];
      read_bank_o <= buf_q[rd_ptr_q][10:8];
    end else if (active_q) begin
      active_q <= beat_q != BURST_LAST;
      beat_q <= 2'(beat_q + 2'd1);
    end
  end

  logic next_active;
  logic [1:0] next_beat;
  logic [7:0] next_pat;
  assign next_active = pop || (active_q && beat_q != BURST_LAST);
  assign next_beat = pop ? 2'd0 : 2'(beat_q + 2'd1);
  assign next_pat = pop ? buf_q[rd_ptr_q][7:0] : pat_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_oe <= 1'b0;
      dq_rise_o <= '0;
      dq_fall_o <= '0;
    end else begin
      dq_oe <= next_active;
      dq_rise_o <= next_active ? {DQ_W{beat_bit(next_pat, next_beat, 1'b0)}} : '0;
      dq_fall_o <= next_active ? {DQ_W{beat_bit(next_pat, next_beat, 1'b1)}} : '0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dqs_oe <= 1'b0;
      dqs_t_o <= 1'b0;
      dqs_c_o <= 1'b1;
    end else begin
      dqs_oe <= next_active;
      dqs_t_o <= next_active && !next_beat[0];
      dqs_c_o <= !(next_active && !next_beat[0]);
    end
  end

  // ==========================================================
  // checks
  read_burst_len_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(dq_oe) |-> dq_oe [*4] ##1 (!dq_oe || $past(pop, 1)))
    else $error("read burst not four clocks long");

  strobe_with_data_a: assert property (@(posedge core_clk) disable iff (rst)
    dqs_oe == dq_oe && (dqs_oe || (!dqs_t_o && dqs_c_o)))
    else $error("strobe driven outside a read burst");

  read_starts_burst_a: assert property (@(posedge core_clk) disable iff (rst)
    (is_read && count_q == 2'd0 && !active_q) |=> ##1 dq_oe)
    else $error("read did not start a burst");

  alt_pattern_a: assert property (@(posedge core_clk) disable iff (rst)
    (pop && buf_q[rd_ptr_q][7:0] == PAT_ALT) |=> dq_rise_o == '0 && dq_fall_o == '0
      ##1 dq_rise_o == '1 && dq_fall_o == '1)
    else $error("burst data wrong for alternating pattern");

  idle_undriven_a: assert property (@(posedge core_clk) disable iff (rst)
    (!active_q && !out_valid) |=> !dq_oe)
    else $error("data lines driven with no burst");

  refresh_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    (is_refresh && !active_q && !out_valid) |=> !dq_oe && !dqs_oe)
    else $error("bus driven during refresh");

  strobe_toggles_a: assert property (@(posedge core_clk) disable iff (rst)
    (dqs_oe && $past(dqs_oe) && !$past(pop, 1)) |-> dqs_t_o != $past(dqs_t_o))
    else $error("strobe did not toggle inside burst");

  fault_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
    sy2_q[SY_WM] |=> protocol_fault)
    else $error("write mask high not flagged");

  back_to_back_c: cover property (@(posedge core_clk) disable iff (rst)
    pop && active_q);
  write_loop_c: cover property (@(posedge core_clk) disable iff (rst)
    is_write && !protocol_fault);
  refresh_loop_c: cover property (@(posedge core_clk) disable iff (rst)
    is_refresh ##4 is_refresh);

endmodule : sdcl_read_path

// File: tb/sdcl_host_model.sv
`timescale 1ns/1ps
module sdcl_host_model import sdcl_pkg::*; #(
  parameter int REFRESH_CYCLES = 40
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // restarts the loop
  input wire logic [2:0] mode, // 0 idle 1 read 2 write 3 refresh 4 read flood
  input wire logic bad_wm, // mask driven high on purpose
  output logic cs_n, // chip select
  output logic ras_n, // row strobe
  output logic cas_n, // column strobe
  output logic we_n, // write enable
  output logic [2:0] ba, // bank
  output logic [13:0] addr, // address
  output logic termination_enable, // termination
  output logic write_mask, // mask
  output logic cke // clock enable
);
  int cyc;
  int u;
  logic rst_seen;
  initial begin
    {cs_n, ras_n, cas_n, we_n, ba, addr, termination_enable, write_mask, cke} = 24'hf00001;
    cyc = 0;
    rst_seen = 1'b1;
  end
  // reset taken at the rising edge, so the bench's falling-edge change cannot race the sequencer
  always @(posedge core_clk) begin
    rst_seen <= rst;
  end
  // =====================================
  // loop sequencer, pins move on the falling edge
  always @(negedge core_clk) begin
    u = (cyc > 32) ? (cyc - 33) % 28 + 4 : cyc - 1;
    cke <= 1'b1;
    write_mask <= bad_wm;
    termination_enable <= (mode == 3'h2);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    ba <= 3'h0;
    addr <= 14'h0;
    if (rst_seen) begin
      cyc <= 0;
    end else begin
      cyc <= (mode == 3'h3 && cyc == REFRESH_CYCLES - 1) ? 0 : (cyc + 1) % 64;
      if (mode == 3'h1 || mode == 3'h2) begin
        ba <= 3'(cyc / 8);
        addr[6:3] <= cyc[2] ? COL_ONES : COL_ZERO;
        if (cyc % 4 == 0) begin
          {cs_n, ras_n, cas_n, we_n} <= {1'b0, (mode == 3'h1) ? CMD_READ : CMD_WRITE};
        end else if (cyc % 4 == 1) begin
          {cs_n, ras_n, cas_n, we_n} <= 4'h8;
        end
      end else if (mode == 3'h3) begin
        ba <= 3'(u / 4);
        addr[6:3] <= (u % 4 > 1) ? COL_ONES : COL_ZERO;
        if (cyc == 0) begin
          {cs_n, ras_n, cas_n, we_n} <= {1'b0, CMD_REFRESH};
        end else if (u % 4 < 2) begin
          {cs_n, ras_n, cas_n, we_n} <= 4'h8;
        end
      end else if (mode == 3'h4) begin
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, CMD_READ};
      end
    end
  end
endmodule : sdcl_host_model

// File: tb/test_sdram_current_loop_patterns.sv
`timescale 1ns/1ps
module test_sdram_current_loop_patterns import sdcl_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] mode = 3'h0;
  logic bad_wm = 1'b0;
  logic cs_n, ras_n, cas_n, we_n, termination_enable, write_mask, cke;
  logic [2:0] ba, read_bank_o;
  logic [13:0] addr;
  logic [7:0] dq_rise_o, dq_fall_o, pat;
  logic dq_oe, dqs_t_o, dqs_c_o, dqs_oe, protocol_fault, read_overrun;
  logic [10:0] rows [16];
  int fail_count = 0;
  int checks = 0;
  int b;
  always #20 core_clk = ~core_clk;
  sdcl_host_model host (.core_clk, .rst, .mode, .bad_wm, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .termination_enable, .write_mask, .cke);
  sdcl_read_path dut (.core_clk, .rst, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .termination_enable,
    .write_mask, .cke, .dq_rise_o, .dq_fall_o, .dq_oe, .dqs_t_o, .dqs_c_o, .dqs_oe, .read_bank_o,
    .protocol_fault, .read_overrun);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic run(input logic [2:0] m, input logic wm);
    mode = m;
    bad_wm = wm;
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("rst", {2'h0, dq_oe, dqs_oe, dqs_t_o, dqs_c_o, protocol_fault, read_overrun}, 8'h04);
    chk("rst_bank", {5'h0, read_bank_o}, 8'h00);
    rst = 1'b0;
  endtask : run
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge core_clk);
      chk("quiet", {6'h0, dq_oe, dqs_oe}, 8'h00);
    end
  endtask : quiet
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // =====================================
  // stimulus
  initial begin
    for (int k = 0; k < 16; k++) begin
      rows[k] = {3'(k / 2), k[0] ? PAT_ALT : PAT_ZERO};
    end
    @(negedge core_clk);
    run(3'h1, 1'b0);
    for (int w = 0; w < 12 && dq_oe !== 1'b1; w++) @(negedge core_clk);
    // bursts sit back to back, so the bus stays driven all 64 clocks
    for (int j = 0; j < 64; j++) begin
      pat = rows[j / 4][7:0];
      b = j % 4;
      chk("rise", {8{pat[7 - 2 * b]}}, dq_rise_o);
      chk("fall", {8{pat[6 - 2 * b]}}, dq_fall_o);
      chk("strobe", {4'h0, dq_oe, dqs_oe, dqs_t_o, dqs_c_o}, {6'h3, ~b[0], b[0]});
      chk("bank", {5'h0, read_bank_o}, {5'h0, rows[j / 4][10:8]});
      @(negedge core_clk);
    end
    chk("fault", {7'h0, protocol_fault}, 8'h00);
    $display("read loop done");
    run(3'h2, 1'b0);
    quiet(70);
    chk("fault", {7'h0, protocol_fault}, 8'h00);
    $display("write loop done");
    run(3'h3, 1'b0);
    quiet(90);
    chk("fault", {7'h0, protocol_fault}, 8'h00);
    $display("refresh loop done");
    run(3'h1, 1'b1);
    repeat (8) @(negedge core_clk);
    chk("mask", {7'h0, protocol_fault}, 8'h01);
    $display("mask test done");
    run(3'h4, 1'b0);
    repeat (20) @(negedge core_clk);
    chk("overrun", {7'h0, read_overrun}, 8'h01);
    $display("flood test done");
    close_out();
  end
  initial begin
    repeat (1500) @(posedge core_clk);
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end
endmodule : test_sdram_current_loop_patterns
